// File: design/dlf_pkg.sv
// Constants, field layout and decoders of the loop feedback configuration bank
// Assumes byte registers reached by a 16-bit address from the serial port
`default_nettype none

package dlf_pkg;

    localparam int NUM_REGS = 21;
    localparam int ADDR_W   = 16;
    localparam int IDX_W    = 5;
    localparam int BW_W     = 4;
    localparam int DAMP_W   = 3;
    localparam int GAIN_W   = 2;

    localparam logic [23:0] RST_DIVIDER  = 24'h070000;
    localparam logic [3:0]  RST_BW       = 4'h7;
    localparam logic [2:0]  RST_DAMP     = 3'h3;
    localparam logic [1:0]  RST_GAIN     = 2'h1;
    localparam logic [7:0]  RST_FIXED_FF = 8'hff;
    localparam logic [7:0]  RST_FIXED_01 = 8'h01;
    localparam logic [7:0]  RST_SLOPE    = 8'h00;
    localparam logic [7:0]  RST_LOCK_WIN = 8'h3f;
    localparam logic [8:0]  RST_DSM_INT  = 9'h02d;
    localparam logic [20:0] RST_DSM_FRAC = 21'h000000;
    localparam logic [7:0]  RST_DITHER   = 8'hd0;
    localparam logic [3:0]  BW_MIN_CODE  = 4'h3;
    localparam logic [3:0]  BW_MAX_CODE  = 4'hb;

    // Byte index of each register in the store
    localparam logic [IDX_W-1:0] IDX_REF0_H = 5'h00;
    localparam logic [IDX_W-1:0] IDX_REF0_M = 5'h01;
    localparam logic [IDX_W-1:0] IDX_REF0_L = 5'h02;
    localparam logic [IDX_W-1:0] IDX_REF1_H = 5'h03;
    localparam logic [IDX_W-1:0] IDX_REF1_M = 5'h04;
    localparam logic [IDX_W-1:0] IDX_REF1_L = 5'h05;
    localparam logic [IDX_W-1:0] IDX_BW     = 5'h06;
    localparam logic [IDX_W-1:0] IDX_DAMP   = 5'h07;
    localparam logic [IDX_W-1:0] IDX_FIX_A  = 5'h08;
    localparam logic [IDX_W-1:0] IDX_SLOPE  = 5'h0c;
    localparam logic [IDX_W-1:0] IDX_LOCK   = 5'h0d;
    localparam logic [IDX_W-1:0] IDX_INT_H  = 5'h0e;
    localparam logic [IDX_W-1:0] IDX_INT_L  = 5'h0f;
    localparam logic [IDX_W-1:0] IDX_FRAC_H = 5'h10;
    localparam logic [IDX_W-1:0] IDX_FRAC_M = 5'h11;
    localparam logic [IDX_W-1:0] IDX_FRAC_L = 5'h12;
    localparam logic [IDX_W-1:0] IDX_FIX_E  = 5'h13;
    localparam logic [IDX_W-1:0] IDX_DITHER = 5'h14;

    localparam logic [ADDR_W-1:0] REG_OFFSETS [NUM_REGS] = '{
        16'h0017, 16'h0018, 16'h0019, 16'h001a, 16'h001b, 16'h001c, 16'h0023,
        16'h0024, 16'h002b, 16'h002c, 16'h002d, 16'h002e, 16'h002f, 16'h0030,
        16'h0031, 16'h0032, 16'h0033, 16'h0034, 16'h0035, 16'h0037, 16'h003a};

    localparam logic [7:0] REG_RESETS [NUM_REGS] = '{
        RST_DIVIDER[23:16], RST_DIVIDER[15:8], RST_DIVIDER[7:0],
        RST_DIVIDER[23:16], RST_DIVIDER[15:8], RST_DIVIDER[7:0],
        {RST_BW, RST_BW}, {RST_DAMP, RST_DAMP, RST_GAIN},
        RST_FIXED_FF, RST_FIXED_FF, RST_FIXED_FF, RST_FIXED_FF,
        RST_SLOPE, RST_LOCK_WIN, {7'h00, RST_DSM_INT[8]}, RST_DSM_INT[7:0],
        {3'h0, RST_DSM_FRAC[20:16]}, RST_DSM_FRAC[15:8], RST_DSM_FRAC[7:0],
        RST_FIXED_01, RST_DITHER};

    // Reserved bits are not stored and read back as zero
    localparam logic [7:0] REG_WMASKS [NUM_REGS] = '{
        8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
        8'hff, 8'hdb, 8'hff, 8'h01, 8'hff, 8'h1f, 8'hff, 8'hff, 8'hff, 8'hf7};

    localparam int BW_LCK_LSB   = 4;
    localparam int BW_ACQ_LSB   = 0;
    localparam int DAMP_LCK_LSB = 5;
    localparam int DAMP_ACQ_LSB = 2;
    localparam int GAIN_LSB     = 0;
    localparam int SLOPE_LSB    = 6;
    localparam int HOLD_LSB     = 3;
    localparam int HOLDAVG_BIT  = 1;
    localparam int QUICK_BIT    = 0;
    localparam int ORD_LSB      = 6;
    localparam int DCXO_LSB     = 4;
    localparam int DITH_LSB     = 0;

    typedef enum logic [2:0] {
        DLF_DAMP_RSVD0 = 3'h0, DLF_DAMP_1 = 3'h1, DLF_DAMP_2 = 3'h2, DLF_DAMP_5 = 3'h3,
        DLF_DAMP_10 = 3'h4, DLF_DAMP_20 = 3'h5, DLF_DAMP_RSVD6 = 3'h6, DLF_DAMP_RSVD7 = 3'h7
    } dlf_damp_t;

    typedef enum logic [1:0] {
        DLF_GAIN_HALF = 2'h0, DLF_GAIN_ONE = 2'h1, DLF_GAIN_ONE_HALF = 2'h2, DLF_GAIN_TWO = 2'h3
    } dlf_gain_t;

    typedef enum logic {
        DLF_MODE_LOCKED  = 1'b0,
        DLF_MODE_ACQUIRE = 1'b1
    } dlf_mode_t;

    function automatic logic [IDX_W:0] dlf_reg_lookup(input logic [ADDR_W-1:0] addr);
        logic [IDX_W:0] res;
        res = '0;
        for (int i = 0; i < NUM_REGS; i++)
        begin
            if (REG_OFFSETS[i] == addr)
            begin
                res = {1'b1, IDX_W'(i)};
            end
        end
        return res;
    endfunction

    function automatic logic dlf_bw_reserved(input logic [BW_W-1:0] code);
        return (code < BW_MIN_CODE) || (code > BW_MAX_CODE);
    endfunction

    function automatic logic dlf_damp_reserved(input logic [DAMP_W-1:0] code);
        return (code == DLF_DAMP_RSVD0) || (code > DLF_DAMP_20);
    endfunction

endpackage

`default_nettype wire

// File: design/dlf_cfg_if.sv
// Carrier between the top, the byte store and the loop setting selector
// Assumes all parties run on sys_clk
`default_nettype none

interface dlf_cfg_if;
    import dlf_pkg::*;

    logic              wr_en;
    logic              rd_en;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
    logic [7:0]        rdata;
    logic [7:0]        bytes [NUM_REGS];
    logic [BW_W-1:0]   lck_bw;
    logic [BW_W-1:0]   acq_bw;
    logic [DAMP_W-1:0] lck_damp;
    logic [DAMP_W-1:0] acq_damp;
    logic              quick;
    logic              locked;
    logic [BW_W-1:0]   act_bw;
    logic [BW_W-1:0]   act_exp;
    dlf_damp_t         act_damp;
    logic              bw_bad;
    logic              damp_bad;
    dlf_mode_t         mode;

    modport store (input wr_en, rd_en, addr, wdata, output rdata, bytes);
    modport sel (input lck_bw, acq_bw, lck_damp, acq_damp, quick, locked,
                 output act_bw, act_exp, act_damp, bw_bad, damp_bad, mode);
endinterface

`default_nettype wire

// File: design/dlf_byte_store.sv
// Byte register store with masked writes and a registered read port
// Assumes one access address per cycle shared by read and write
`default_nettype none

module dlf_byte_store
    import dlf_pkg::*;
#(
    parameter int N = NUM_REGS
)
(
    input  wire logic sys_clk,
    input  wire logic rst,
    dlf_cfg_if.store  bus
);

    if (N != NUM_REGS)
    begin : g_chk_n
        $error("dlf_byte_store: N must equal the register count");
    end

    logic [7:0]     mem_reg [N];
    logic [7:0]     mem_next [N];
    logic [7:0]     rdata_reg;
    logic [7:0]     rdata_next;
    logic [IDX_W:0] hit;

    always_comb
    begin
        hit        = dlf_reg_lookup(bus.addr);
        mem_next   = mem_reg;
        rdata_next = rdata_reg;
        if (bus.wr_en && hit[IDX_W])
        begin
            mem_next[hit[IDX_W-1:0]] = bus.wdata & REG_WMASKS[hit[IDX_W-1:0]];
        end
        // A read in the same cycle as a write returns the old value
        if (bus.rd_en)
        begin
            rdata_next = hit[IDX_W] ? mem_reg[hit[IDX_W-1:0]] : 8'h00;
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < N; i++)
            begin
                mem_reg[i] <= REG_RESETS[i];
            end
            rdata_reg <= 8'h00;
        end
        else
        begin
            mem_reg   <= mem_next;
            rdata_reg <= rdata_next;
        end
    end

    assign bus.rdata = rdata_reg;
    assign bus.bytes = mem_reg;

endmodule

`default_nettype wire

// File: design/dlf_loop_select.sv
// Picks the bandwidth and damping that the loop filter applies
// Assumes phase lock status is synchronous to sys_clk
`default_nettype none

module dlf_loop_select
    import dlf_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic rst,
    dlf_cfg_if.sel    sel
);

    dlf_mode_t       mode_reg,     mode_next;
    logic [BW_W-1:0] bw_reg,       bw_next;
    logic [BW_W-1:0] exp_reg,      exp_next;
    dlf_damp_t       damp_reg,     damp_next;
    logic            bw_bad_reg,   bw_bad_next;
    logic            damp_bad_reg, damp_bad_next;

    always_comb
    begin
        mode_next = (sel.quick && !sel.locked) ? DLF_MODE_ACQUIRE : DLF_MODE_LOCKED;
        unique case (mode_next)
            DLF_MODE_LOCKED:
            begin
                bw_next   = sel.lck_bw;
                damp_next = dlf_damp_t'(sel.lck_damp);
            end
            DLF_MODE_ACQUIRE:
            begin
                bw_next   = sel.acq_bw;
                damp_next = dlf_damp_t'(sel.acq_damp);
            end
        endcase
        bw_bad_next   = dlf_bw_reserved(bw_next);
        damp_bad_next = dlf_damp_reserved(damp_next);
        // Exponent n means 1.40625 Hz times two to the n
        exp_next      = bw_bad_next ? 4'h0 : bw_next - BW_MIN_CODE;
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            mode_reg     <= DLF_MODE_LOCKED;
            bw_reg       <= RST_BW;
            exp_reg      <= RST_BW - BW_MIN_CODE;
            damp_reg     <= dlf_damp_t'(RST_DAMP);
            bw_bad_reg   <= 1'b0;
            damp_bad_reg <= 1'b0;
        end
        else
        begin
            mode_reg     <= mode_next;
            bw_reg       <= bw_next;
            exp_reg      <= exp_next;
            damp_reg     <= damp_next;
            bw_bad_reg   <= bw_bad_next;
            damp_bad_reg <= damp_bad_next;
        end
    end

    assign sel.mode     = mode_reg;
    assign sel.act_bw   = bw_reg;
    assign sel.act_exp  = exp_reg;
    assign sel.act_damp = damp_reg;
    assign sel.bw_bad   = bw_bad_reg;
    assign sel.damp_bad = damp_bad_reg;

endmodule

`default_nettype wire

// File: design/dlf_config_top.sv
// Feedback and loop filter configuration bank of the first digital PLL
// Assumes the serial port front end hands over decoded byte accesses
// synchronous to sys_clk; field ports come straight from the byte store, while the active ratio and loop settings pass one register stage
`default_nettype none

// Overview of operation
// - Ref 0 divider ratio, 24 bits, resets 070000h
// - Ref 1 divider ratio, 24 bits, resets 070000h
// - Locked bandwidth code, doubling from 1.40625Hz
// - Acquisition bandwidth code, same mapping, default 0111
// - Locked damping code, 1 to 20, default 011
// - Acquisition damping code, same mapping, default 011
// - Loop filter gain code 0.5 to 2, default 01
// - Quick acquire uses acquisition settings until lock
module dlf_config_top
    import dlf_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        cfg_wr_en,
    input  wire logic        cfg_rd_en,
    input  wire logic [15:0] cfg_addr,
    input  wire logic [7:0]  cfg_wdata,
    input  wire logic        ref_select,
    input  wire logic        phase_locked,
    output logic      [7:0]  cfg_rdata,
    output logic             cfg_rd_valid,
    output logic      [23:0] ref0_feedback_ratio,
    output logic      [23:0] ref1_feedback_ratio,
    output logic      [23:0] active_feedback_ratio,
    output logic      [3:0]  locked_bandwidth_field,
    output logic      [3:0]  acquisition_bandwidth_field,
    output logic      [2:0]  locked_damping_field,
    output logic      [2:0]  acquisition_damping_field,
    output logic      [1:0]  loop_filter_gain_field,
    output logic             quick_acquire_enable,
    output logic      [3:0]  active_bandwidth_code,
    output logic      [3:0]  active_bandwidth_exp,
    output logic      [2:0]  active_damping_code,
    output logic             bandwidth_code_reserved,
    output logic             damping_code_reserved,
    output logic             acquire_mode,
    output logic      [1:0]  phase_slope_limit,
    output logic      [1:0]  holdover_average_mode,
    output logic             holdover_average_enable,
    output logic      [7:0]  lock_window_field,
    output logic      [8:0]  modulator_integer_part,
    output logic      [20:0] modulator_fraction_part,
    output logic      [1:0]  modulator_order_field,
    output logic      [1:0]  oscillator_error_gain,
    output logic      [2:0]  dither_gain_field
);

    dlf_cfg_if cfg_bus ();

    logic [23:0] active_ratio_reg;
    logic [23:0] active_ratio_next;
    logic        rd_valid_reg;
    logic        rd_valid_next;

    dlf_byte_store #(
        .N (NUM_REGS)
    ) u_store (
        .sys_clk (sys_clk),
        .rst     (rst),
        .bus     (cfg_bus)
    );

    dlf_loop_select u_select (
        .sys_clk (sys_clk),
        .rst     (rst),
        .sel     (cfg_bus)
    );

    assign cfg_bus.wr_en = cfg_wr_en;
    assign cfg_bus.rd_en = cfg_rd_en;
    assign cfg_bus.addr  = cfg_addr;
    assign cfg_bus.wdata = cfg_wdata;

    // Selector sees the stored codes and the live lock status
    assign cfg_bus.lck_bw   = cfg_bus.bytes[IDX_BW][BW_LCK_LSB +: BW_W];
    assign cfg_bus.acq_bw   = cfg_bus.bytes[IDX_BW][BW_ACQ_LSB +: BW_W];
    assign cfg_bus.lck_damp = cfg_bus.bytes[IDX_DAMP][DAMP_LCK_LSB +: DAMP_W];
    assign cfg_bus.acq_damp = cfg_bus.bytes[IDX_DAMP][DAMP_ACQ_LSB +: DAMP_W];
    assign cfg_bus.quick    = cfg_bus.bytes[IDX_SLOPE][QUICK_BIT];
    assign cfg_bus.locked   = phase_locked;

    // The ratio follows the reference choice and each byte write one cycle
    // later, so the divider sees a mix of old and new bytes mid-write
    always_comb
    begin
        rd_valid_next     = cfg_rd_en;
        active_ratio_next = ref_select ? ref1_feedback_ratio : ref0_feedback_ratio;
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            rd_valid_reg     <= 1'b0;
            active_ratio_reg <= RST_DIVIDER;
        end
        else
        begin
            rd_valid_reg     <= rd_valid_next;
            active_ratio_reg <= active_ratio_next;
        end
    end

    assign cfg_rdata             = cfg_bus.rdata;
    assign cfg_rd_valid          = rd_valid_reg;
    assign active_feedback_ratio = active_ratio_reg;

    assign ref0_feedback_ratio = {cfg_bus.bytes[IDX_REF0_H],
                                  cfg_bus.bytes[IDX_REF0_M],
                                  cfg_bus.bytes[IDX_REF0_L]};
    assign ref1_feedback_ratio = {cfg_bus.bytes[IDX_REF1_H],
                                  cfg_bus.bytes[IDX_REF1_M],
                                  cfg_bus.bytes[IDX_REF1_L]};

    assign locked_bandwidth_field      = cfg_bus.lck_bw;
    assign acquisition_bandwidth_field = cfg_bus.acq_bw;
    assign locked_damping_field        = cfg_bus.lck_damp;
    assign acquisition_damping_field   = cfg_bus.acq_damp;
    assign loop_filter_gain_field      = cfg_bus.bytes[IDX_DAMP][GAIN_LSB +: GAIN_W];
    assign quick_acquire_enable        = cfg_bus.quick;

    assign active_bandwidth_code   = cfg_bus.act_bw;
    assign active_bandwidth_exp    = cfg_bus.act_exp;
    assign active_damping_code     = cfg_bus.act_damp;
    assign bandwidth_code_reserved = cfg_bus.bw_bad;
    assign damping_code_reserved   = cfg_bus.damp_bad;
    assign acquire_mode            = (cfg_bus.mode == DLF_MODE_ACQUIRE);

    assign phase_slope_limit       = cfg_bus.bytes[IDX_SLOPE][SLOPE_LSB +: 2];
    assign holdover_average_mode   = cfg_bus.bytes[IDX_SLOPE][HOLD_LSB +: 2];
    assign holdover_average_enable = cfg_bus.bytes[IDX_SLOPE][HOLDAVG_BIT];
    assign lock_window_field       = cfg_bus.bytes[IDX_LOCK];
    assign modulator_integer_part  = {cfg_bus.bytes[IDX_INT_H][0],
                                      cfg_bus.bytes[IDX_INT_L]};
    assign modulator_fraction_part = {cfg_bus.bytes[IDX_FRAC_H][4:0],
                                      cfg_bus.bytes[IDX_FRAC_M],
                                      cfg_bus.bytes[IDX_FRAC_L]};
    assign modulator_order_field   = cfg_bus.bytes[IDX_DITHER][ORD_LSB +: 2];
    assign oscillator_error_gain   = cfg_bus.bytes[IDX_DITHER][DCXO_LSB +: 2];
    assign dither_gain_field       = cfg_bus.bytes[IDX_DITHER][DITH_LSB +: 3];

    // Checks

    logic [IDX_W:0]   chk_lookup;
    logic             chk_wr;
    logic [IDX_W-1:0] chk_idx;

    assign chk_lookup = dlf_reg_lookup(cfg_addr);
    assign chk_wr     = cfg_wr_en && chk_lookup[IDX_W];
    assign chk_idx    = chk_lookup[IDX_W-1:0];

    default clocking cb @(posedge sys_clk);
    endclocking

    default disable iff (rst);

    a_ratio_reset_value: assert property (
        $fell(rst) |-> (ref0_feedback_ratio == RST_DIVIDER) && (ref1_feedback_ratio == RST_DIVIDER))
        else $error("divider ratio reset value wrong");

    a_ref0_high_byte: assert property (
        chk_wr && (chk_idx == IDX_REF0_H) |=> ref0_feedback_ratio[23:16] == $past(cfg_wdata))
        else $error("ref0 high byte not stored in upper bits");

    a_ref1_low_byte: assert property (
        chk_wr && (chk_idx == IDX_REF1_L)
        |=> (ref1_feedback_ratio[7:0] == $past(cfg_wdata))
            && (ref1_feedback_ratio[23:8] == $past(ref1_feedback_ratio[23:8])))
        else $error("ref1 low byte write wrong");

    a_active_ratio_pick: assert property (
        ref_select ##1 ref_select |-> active_feedback_ratio == $past(ref1_feedback_ratio))
        else $error("active ratio not from ref1");

    a_bw_field_write: assert property (
        chk_wr && (chk_idx == IDX_BW)
        |=> (locked_bandwidth_field == $past(cfg_wdata[7:4]))
            && (acquisition_bandwidth_field == $past(cfg_wdata[3:0])))
        else $error("bandwidth fields not updated");

    a_gain_damp_write: assert property (
        chk_wr && (chk_idx == IDX_DAMP)
        |=> (loop_filter_gain_field == $past(cfg_wdata[1:0]))
            && (locked_damping_field == $past(cfg_wdata[7:5])))
        else $error("damping or gain field not updated");

    a_locked_settings: assert property (
        (!quick_acquire_enable || phase_locked)
        |=> (active_bandwidth_code == $past(locked_bandwidth_field))
            && (active_damping_code == $past(locked_damping_field)) && !acquire_mode)
        else $error("locked settings not applied");

    a_acquire_settings: assert property (
        (quick_acquire_enable && !phase_locked)
        |=> (active_bandwidth_code == $past(acquisition_bandwidth_field))
            && (active_damping_code == $past(acquisition_damping_field)) && acquire_mode)
        else $error("acquisition settings not applied");

    a_bw_exponent: assert property (
        !bandwidth_code_reserved |-> active_bandwidth_exp == 4'(active_bandwidth_code - BW_MIN_CODE))
        else $error("bandwidth exponent mismatch");

    a_damp_reserved: assert property (
        damping_code_reserved |-> (active_damping_code == 3'h0) || (active_damping_code > 3'h5))
        else $error("damping reserved flag wrong");

    a_fixed_reset: assert property (
        $fell(rst) |-> (cfg_bus.bytes[IDX_FIX_A] == RST_FIXED_FF) && (cfg_bus.bytes[IDX_FIX_E] == RST_FIXED_01))
        else $error("fixed pattern reset value wrong");

    a_read_answer: assert property (
        cfg_rd_en && chk_lookup[IDX_W] && !cfg_wr_en |=> cfg_rd_valid ##0 cfg_rdata == $past(cfg_bus.bytes[chk_idx]))
        else $error("read data wrong");

    a_read_valid_pulse: assert property (
        !cfg_rd_en |=> !cfg_rd_valid)
        else $error("read valid without a read");

    a_unmapped_read: assert property (
        cfg_rd_en && !chk_lookup[IDX_W] |=> cfg_rdata == 8'h00)
        else $error("unmapped read not zero");

    a_unmapped_write: assert property (
        cfg_wr_en && !chk_lookup[IDX_W] |=> $stable(ref0_feedback_ratio) && $stable(ref1_feedback_ratio))
        else $error("unmapped write changed a ratio");

    a_bw_field_reset: assert property (
        $fell(rst) |-> (locked_bandwidth_field == RST_BW) && (acquisition_bandwidth_field == RST_BW))
        else $error("bandwidth reset value wrong");

    a_damp_gain_reset: assert property (
        $fell(rst) |-> (loop_filter_gain_field == RST_GAIN) && (locked_damping_field == RST_DAMP)
            && (acquisition_damping_field == RST_DAMP))
        else $error("damping or gain reset value wrong");

    a_bw_reserved_flag: assert property (
        bandwidth_code_reserved == ((active_bandwidth_code < BW_MIN_CODE) || (active_bandwidth_code > BW_MAX_CODE)))
        else $error("bandwidth reserved flag wrong");

    a_reserved_exp_zero: assert property (
        bandwidth_code_reserved |-> active_bandwidth_exp == 4'h0)
        else $error("reserved bandwidth exponent not zero");

    a_damp_flag_set: assert property (
        (active_damping_code == 3'h0) || (active_damping_code > 3'h5) |-> damping_code_reserved)
        else $error("reserved damping code not flagged");

    a_active_ratio_ref0: assert property (
        !ref_select ##1 !ref_select |-> active_feedback_ratio == $past(ref0_feedback_ratio))
        else $error("active ratio not from ref0");

    a_reserved_bits_drop: assert property (
        chk_wr && (chk_idx == IDX_SLOPE) |=> cfg_bus.bytes[IDX_SLOPE] == ($past(cfg_wdata) & REG_WMASKS[IDX_SLOPE]))
        else $error("reserved bits stored");

    c_ref0_write: cover property (chk_wr && (chk_idx == IDX_REF0_H));

    c_acquire_to_lock: cover property (acquire_mode ##1 !acquire_mode && quick_acquire_enable);

    c_reserved_bw: cover property (bandwidth_code_reserved);

    c_ref_switch: cover property (ref_select ##1 !ref_select);

endmodule

`default_nettype wire

// File: test/dlf_config_top_tb.sv
// Self-checking bench of the loop feedback configuration bank
// Assumes the plain byte strobe port of dlf_config_top, inputs driven on the falling edge
`default_nettype none

module dlf_config_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import dlf_pkg::*;

    logic        sys_clk, rst, cfg_wr_en, cfg_rd_en, ref_select, phase_locked, rd_valid;
    logic [15:0] cfg_addr;
    logic [7:0]  cfg_wdata, rdata;
    logic [23:0] r0, r1, ract;
    logic [3:0]  lbw, abw, act_bw, act_exp;
    logic [2:0]  ldmp, admp, act_dmp;
    logic [1:0]  gain;
    logic        quick, bw_rsv, dmp_rsv, acq;
    logic [1:0]  slope, hmode, ord, oscg;
    logic        havg;
    logic [7:0]  lwin;
    logic [8:0]  dint;
    logic [20:0] dfrac;
    logic [2:0]  dith;
    int          err_total = 0;
    int          checks = 0;
    // Expected reset bytes in store order
    logic [7:0]  rst_tab [NUM_REGS] = '{8'h07, 8'h00, 8'h00, 8'h07, 8'h00, 8'h00, 8'h77, 8'h6d, 8'hff,
        8'hff, 8'hff, 8'hff, 8'h00, 8'h3f, 8'h00, 8'h2d, 8'h00, 8'h00, 8'h00, 8'h01, 8'hd0};

    dlf_config_top dut (.sys_clk(sys_clk), .rst(rst), .cfg_wr_en(cfg_wr_en), .cfg_rd_en(cfg_rd_en),
        .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .ref_select(ref_select), .phase_locked(phase_locked),
        .cfg_rdata(rdata), .cfg_rd_valid(rd_valid), .ref0_feedback_ratio(r0), .ref1_feedback_ratio(r1),
        .active_feedback_ratio(ract), .locked_bandwidth_field(lbw), .acquisition_bandwidth_field(abw),
        .locked_damping_field(ldmp), .acquisition_damping_field(admp), .loop_filter_gain_field(gain),
        .quick_acquire_enable(quick), .active_bandwidth_code(act_bw), .active_bandwidth_exp(act_exp),
        .active_damping_code(act_dmp), .bandwidth_code_reserved(bw_rsv), .damping_code_reserved(dmp_rsv),
        .acquire_mode(acq), .phase_slope_limit(slope), .holdover_average_mode(hmode),
        .holdover_average_enable(havg), .lock_window_field(lwin), .modulator_integer_part(dint),
        .modulator_fraction_part(dfrac), .modulator_order_field(ord), .oscillator_error_gain(oscg),
        .dither_gain_field(dith));

    initial
    begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
        checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        cfg_wr_en = 1'b1;
        cfg_addr  = a;
        cfg_wdata = d;
        @(negedge sys_clk);
        cfg_wr_en = 1'b0;
    endtask

    // Valid and data are due exactly one cycle after the strobe
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(negedge sys_clk);
        cfg_rd_en = 1'b1;
        cfg_addr  = a;
        @(negedge sys_clk);
        cfg_rd_en = 1'b0;
        chk({23'h0, rd_valid}, 24'h1, "read valid");
        chk({16'h0, rdata}, {16'h0, e}, "read data");
    endtask

    task automatic reset_values();
        for (int i = 0; i < NUM_REGS; i++)
            rd(REG_OFFSETS[i], rst_tab[i]);
        chk(r0, 24'h070000, "ref0 ratio");
        chk(r1, 24'h070000, "ref1 ratio");
        chk({lbw, abw}, 24'h77, "bandwidth");
        chk({ldmp, admp, gain}, 24'h6d, "damping gain");
        chk({slope, hmode, havg, quick}, 24'h0, "slope holdover quick");
        chk({dint, lwin}, 24'h02d3f, "modulator integer, lock window");
        chk({3'h0, dfrac}, 24'h0, "modulator fraction");
        chk({ord, oscg, dith}, 24'h68, "modulator order gains");
    endtask

    task automatic modulator_fields();
        wr(16'h0030, 8'h5c);
        wr(16'h0031, 8'h01);
        wr(16'h0032, 8'h23);
        wr(16'h0033, 8'h1a);
        wr(16'h003a, 8'h97);
        chk({dint, lwin}, 24'h1235c, "modulator integer, lock window");
        chk({3'h0, dfrac}, 24'h1a0000, "modulator fraction");
        chk({ord, oscg, dith}, 24'h4f, "modulator order gains");
    endtask

    task automatic ratio_bytes();
        wr(16'h0017, 8'h12);
        chk(r0, 24'h120000, "ref0 high byte alone");
        wr(16'h0018, 8'h34);
        wr(16'h0019, 8'h56);
        chk(r0, 24'h123456, "ref0 ratio");
        wr(16'h001a, 8'hab);
        wr(16'h001b, 8'hcd);
        wr(16'h001c, 8'hef);
        chk(r1, 24'habcdef, "ref1 ratio");
        chk(ract, 24'h123456, "ratio ref0 in use");
        ref_select = 1'b1;
        repeat (2) @(negedge sys_clk);
        chk(ract, 24'habcdef, "ratio ref1 in use");
        rd(16'h001a, 8'hab);
    endtask

    task automatic bandwidth_codes();
        logic [3:0] c;
        logic       rs;
        for (int i = 0; i < 16; i++)
        begin
            c  = 4'(i);
            rs = (c < 4'h3) || (c > 4'hb);
            wr(16'h0023, {c, ~c});
            @(negedge sys_clk);
            chk({lbw, abw}, {16'h0, c, ~c}, "bandwidth fields");
            chk({act_bw, act_exp}, {16'h0, c, rs ? 4'h0 : c - 4'h3}, "bandwidth in force");
            chk({23'h0, bw_rsv}, {23'h0, rs}, "bandwidth reserved flag");
        end
    endtask

    task automatic damping_gain_codes();
        logic [2:0] d;
        for (int i = 0; i < 8; i++)
        begin
            d = 3'(i);
            wr(16'h0024, {d, ~d, d[1:0]});
            @(negedge sys_clk);
            chk({ldmp, admp, gain}, {16'h0, d, ~d, d[1:0]}, "damping gain fields");
            chk({act_dmp, dmp_rsv}, {20'h0, d, (d == 3'h0) || (d > 3'h5)}, "damping in force");
        end
        rd(16'h0024, 8'he3);
    endtask

    task automatic quick_acquire();
        wr(16'h0023, 8'h59);
        wr(16'h0024, 8'h31);
        @(negedge sys_clk);
        chk({act_bw, act_dmp, acq}, 24'h52, "locked settings, quick off");
        wr(16'h002f, 8'h01);
        @(negedge sys_clk);
        chk({act_bw, act_dmp, acq}, 24'h99, "acquire settings");
        phase_locked = 1'b1;
        @(negedge sys_clk);
        chk({act_bw, act_dmp, acq}, 24'h52, "locked after lock");
    endtask

    // Reserved bits read zero, unmapped places hold nothing
    task automatic reserved_places();
        wr(16'h002f, 8'hff);
        rd(16'h002f, 8'hdb);
        chk({slope, hmode, havg, quick}, 24'h3f, "slope holdover quick");
        wr(16'h001d, 8'h5a);
        rd(16'h001d, 8'h00);
        rd(16'h0017, 8'h12);
    endtask

    task automatic end_sim();
        $display("checks %0d, mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        #400000;
        err_total++;
        $display("mismatch at %0t: run did not finish", $time);
        end_sim();
    end

    initial
    begin
        rst = 1'b1;
        {cfg_wr_en, cfg_rd_en, ref_select, phase_locked} = 4'h0;
        cfg_addr  = 16'h0000;
        cfg_wdata = 8'h00;
        repeat (20) @(negedge sys_clk);
        rst = 1'b0;
        reset_values();
        ratio_bytes();
        bandwidth_codes();
        damping_gain_codes();
        quick_acquire();
        reserved_places();
        modulator_fields();
        end_sim();
    end
endmodule

`default_nettype wire
